// ==== hw/bridge_reset_and_clock_control.sv ====
// Power-on reset, software reset, status flag and system clock control.
`timescale 1ns/1ps
`include "bridge_reset_defines.svh"

module bridge_reset_and_clock_control
	import bridge_reset_pkg::*;
#(
	parameter int POR_DELAY = `POR_DELAY_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic SUPPLY_LOW,
	input wire logic PWM_IN,
	input wire logic CMD_STROBE,
	input wire frame_id_t CMD_FRAME,
	input wire logic [15:0] CMD_DATA,
	input wire logic ANS_STROBE,
	input wire frame_id_t ANS_FRAME,
	output logic [11:0] ANS_DATA,
	input wire logic SELF_TEST_DONE,
	input wire logic SELF_TEST_OK,
	output logic SELF_TEST_REQUEST,
	output logic POR_N,
	output logic LOGIC_RESET,
	output logic BRIDGE_HIZ,
	output logic SYS_TICK
);

	localparam int CW = $clog2(POR_DELAY + 1);
	localparam int REL_AT = POR_DELAY - 3;
	localparam int SW_LEN = 15;

	function automatic logic [3:0] sys_period(input logic dis,
		input logic [1:0] step);
		logic [3:0] p;
		p = `SYS_PERIOD_NOM;
		if (!dis) begin
			case (step)
				2'h1: p = `SYS_PERIOD_LOW;
				2'h3: p = `SYS_PERIOD_HIGH;
				default: p = `SYS_PERIOD_NOM;
			endcase
		end
		return p;
	endfunction

	logic por_s1_reg, por_s1_next;
	logic por_s2_reg, por_s2_next;
	logic por_n_reg, por_n_next;
	logic [CW-1:0] por_cnt_reg, por_cnt_next;

	bridge_state_t state_reg, state_next;
	logic [2:0] st_status_reg, st_status_next;
	logic flag_reg, flag_next;
	logic spread_reg, spread_next;
	logic echo_reg, echo_next;
	logic [1:0] sw_cnt_reg, sw_cnt_next;
	logic [3:0] div_reg, div_next;
	logic [1:0] step_reg, step_next;
	logic tick_reg, tick_next;
	logic req_reg, req_next;
	logic pwm_s1_reg, pwm_s1_next;
	logic pwm_s2_reg, pwm_s2_next;
	logic pwm_prev_reg, pwm_prev_next;
	logic [11:0] ans_reg, ans_next;

	logic sw_active;
	logic logic_rst;
	logic rst_any;
	logic cmd_ctrl;
	logic sw_accept;
	logic st_trigger;
	logic spread_wr;
	logic flag_clear;
	logic pwm_edge;
	logic tick_now;
	logic [3:0] period;

	// Release path of the power-on reset: a two-stage reset synchroniser
	// followed by the power-up release delay.
	always_comb begin
		por_s1_next = ~RESET;
		por_s2_next = ~RESET & por_s1_reg;
		por_cnt_next = por_cnt_reg;
		por_n_next = por_n_reg;
		if (RESET) begin
			por_cnt_next = '0;
			por_n_next = 1'b0;
		end else if (!por_n_reg && por_s2_reg) begin
			if (por_cnt_reg == CW'(REL_AT)) begin
				por_n_next = 1'b1;
			end else begin
				por_cnt_next = por_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge SUPPLY_LOW) begin
		if (SUPPLY_LOW) begin
			por_s1_reg <= 1'b0;
			por_s2_reg <= 1'b0;
			por_n_reg <= 1'b0;
			por_cnt_reg <= '0;
		end else begin
			por_s1_reg <= por_s1_next;
			por_s2_reg <= por_s2_next;
			por_n_reg <= por_n_next;
			por_cnt_reg <= por_cnt_next;
		end
	end

	assign sw_active = sw_cnt_reg != 2'h0;
	assign logic_rst = ~por_n_reg | sw_active;
	assign rst_any = RESET | logic_rst;
	assign cmd_ctrl = CMD_STROBE && CMD_FRAME == `CMD_FRAME_CTRL && !rst_any;
	assign sw_accept = cmd_ctrl &&
		CMD_DATA[`SW_RESET_MSB:`SW_RESET_LSB] == `SW_RESET_CODE;
	assign st_trigger = cmd_ctrl && !sw_accept && CMD_DATA[`SELF_TEST_BIT];
	assign spread_wr = CMD_STROBE && CMD_FRAME == `CMD_FRAME_CLK && !rst_any;
	assign flag_clear = ANS_STROBE && ANS_FRAME == `ANS_FRAME_7E;
	assign pwm_edge = pwm_s2_reg ^ pwm_prev_reg;
	assign period = sys_period(spread_reg, step_reg);
	assign tick_now = div_reg == period - 4'h1;

	always_comb begin
		div_next = div_reg + 4'h1;
		step_next = step_reg;
		tick_next = tick_now;
		// A software reset restarts the divider so its length is exact.
		if (RESET || sw_accept) begin
			div_next = 4'h0;
			step_next = 2'h0;
		end else if (tick_now) begin
			div_next = 4'h0;
			step_next = step_reg + 2'h1;
		end

		sw_cnt_next = sw_cnt_reg;
		if (RESET) begin
			sw_cnt_next = 2'h0;
		end else if (sw_accept) begin
			sw_cnt_next = `SW_RESET_TICKS;
		end else if (sw_active && tick_now) begin
			sw_cnt_next = sw_cnt_reg - 2'h1;
		end

		flag_next = flag_reg;
		if (rst_any) begin
			flag_next = `RESET_FLAG_INIT;
		end else if (flag_clear) begin
			flag_next = 1'b0;
		end

		spread_next = spread_reg;
		if (rst_any) begin
			spread_next = `SPREAD_INIT;
		end else if (spread_wr) begin
			spread_next = CMD_DATA[`SPREAD_BIT];
		end
		echo_next = spread_next;

		pwm_s1_next = PWM_IN;
		pwm_s2_next = pwm_s1_reg;
		pwm_prev_next = pwm_s2_reg;
	end

	// Self-test gate: the bridge may leave tri-state only after a pass.
	always_comb begin
		state_next = state_reg;
		st_status_next = st_status_reg;
		req_next = 1'b0;
		if (rst_any) begin
			state_next = ST_DISABLED;
			st_status_next = `ST_NOT_DONE;
		end else begin
			case (state_reg)
				ST_DISABLED: begin
					if (st_trigger) begin
						state_next = ST_TESTING;
						req_next = 1'b1;
					end
				end
				ST_TESTING: begin
					if (SELF_TEST_DONE) begin
						if (SELF_TEST_OK) begin
							state_next = ST_PASSED;
							st_status_next = `ST_PASS;
						end else begin
							state_next = ST_DISABLED;
							st_status_next = `ST_FAIL;
						end
					end
				end
				ST_PASSED: begin
					if (pwm_edge) begin
						state_next = ST_NORMAL;
					end
				end
				ST_NORMAL: begin
					state_next = ST_NORMAL;
				end
				default: begin
					state_next = ST_DISABLED;
				end
			endcase
		end
	end

	always_comb begin
		ans_next = ans_reg;
		if (ANS_STROBE) begin
			ans_next = 12'h000;
			case (ANS_FRAME)
				`ANS_FRAME_4: ans_next[`SPREAD_BIT] = spread_reg;
				`ANS_FRAME_7B: ans_next[`SPREAD_BIT] = echo_reg;
				`ANS_FRAME_7E: ans_next[`FLAG_BIT] = flag_reg;
				`ANS_FRAME_8A: begin
					ans_next[`ST_STATUS_LSB +: 3] = st_status_reg;
				end
				default: ans_next = 12'h000;
			endcase
		end else if (RESET) begin
			ans_next = 12'h000;
		end
	end

	always_ff @(posedge REF_CLK or posedge SUPPLY_LOW) begin
		if (SUPPLY_LOW) begin
			state_reg <= ST_DISABLED;
			st_status_reg <= `ST_NOT_DONE;
			flag_reg <= `RESET_FLAG_INIT;
			spread_reg <= `SPREAD_INIT;
			echo_reg <= `SPREAD_INIT;
			sw_cnt_reg <= 2'h0;
			div_reg <= 4'h0;
			step_reg <= 2'h0;
			tick_reg <= 1'b0;
			req_reg <= 1'b0;
			pwm_s1_reg <= 1'b0;
			pwm_s2_reg <= 1'b0;
			pwm_prev_reg <= 1'b0;
			ans_reg <= 12'h000;
		end else begin
			state_reg <= state_next;
			st_status_reg <= st_status_next;
			flag_reg <= flag_next;
			spread_reg <= spread_next;
			echo_reg <= echo_next;
			sw_cnt_reg <= sw_cnt_next;
			div_reg <= div_next;
			step_reg <= step_next;
			tick_reg <= tick_next;
			req_reg <= req_next;
			pwm_s1_reg <= pwm_s1_next;
			pwm_s2_reg <= pwm_s2_next;
			pwm_prev_reg <= pwm_prev_next;
			ans_reg <= ans_next;
		end
	end

	assign POR_N = por_n_reg;
	assign LOGIC_RESET = logic_rst;
	assign BRIDGE_HIZ = logic_rst | (state_reg != ST_NORMAL);
	assign SYS_TICK = tick_reg;
	assign SELF_TEST_REQUEST = req_reg;
	assign ANS_DATA = ans_reg;

	// Helper counters watched only by the properties below.
	logic [CW:0] rel_wait;
	logic [4:0] sw_len;
	logic [3:0] gap;

	always_ff @(posedge REF_CLK or posedge SUPPLY_LOW) begin
		if (SUPPLY_LOW) begin
			rel_wait <= '0;
			sw_len <= 5'h00;
			gap <= 4'h0;
		end else begin
			if (RESET || por_n_reg) begin
				rel_wait <= '0;
			end else if (!(&rel_wait)) begin
				rel_wait <= rel_wait + 1'b1;
			end
			if (sw_accept) begin
				sw_len <= 5'h00;
			end else if (sw_active) begin
				sw_len <= sw_len + 5'h01;
			end
			if (tick_now || sw_accept || RESET) begin
				gap <= 4'h0;
			end else begin
				gap <= gap + 4'h1;
			end
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET || SUPPLY_LOW);

	property p_hiz_por;
		!por_n_reg |-> BRIDGE_HIZ;
	endproperty
	a_hiz_por: assert property (p_hiz_por)
		else $error("bridge not tri-stated during power-on reset");

	property p_hiz_rst;
		logic_rst |-> BRIDGE_HIZ ##1 state_reg == ST_DISABLED;
	endproperty
	a_hiz_rst: assert property (p_hiz_rst)
		else $error("bridge left enabled during internal reset");

	property p_defaults;
		$rose(por_n_reg) |-> !spread_reg && flag_reg &&
			st_status_reg == `ST_NOT_DONE;
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("settings not at defaults on reset release");

	property p_release;
		rel_wait <= POR_DELAY;
	endproperty
	a_release: assert property (p_release)
		else $error("power-on reset held longer than release delay");

	property p_normal_entry;
		$changed(state_reg) && state_reg == ST_NORMAL |->
			$past(state_reg) == ST_PASSED && $past(pwm_edge);
	endproperty
	a_normal_entry: assert property (p_normal_entry)
		else $error("normal mode entered without pass and PWM edge");

	property p_sw_no_por;
		sw_accept |=> por_n_reg ##1 por_n_reg;
	endproperty
	a_sw_no_por: assert property (p_sw_no_por)
		else $error("software reset disturbed power-on reset");

	property p_sw_ignore;
		cmd_ctrl && CMD_DATA[`SW_RESET_MSB:`SW_RESET_LSB] != 2'h1 |=>
			!sw_active;
	endproperty
	a_sw_ignore: assert property (p_sw_ignore)
		else $error("software reset started by a wrong code");

	property p_sw_len;
		$fell(sw_active) && !$past(RESET) |-> sw_len == SW_LEN;
	endproperty
	a_sw_len: assert property (p_sw_len)
		else $error("software reset length not two system clocks");

	property p_flag_set;
		logic_rst |=> flag_reg;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("reset flag not set by reset");

	property p_flag_clr;
		flag_clear && !rst_any |=> !flag_reg;
	endproperty
	a_flag_clr: assert property (p_flag_clr)
		else $error("reset flag not cleared by read");

	property p_spread;
		spread_wr |=> spread_reg == $past(CMD_DATA[`SPREAD_BIT]) &&
			echo_reg == spread_reg;
	endproperty
	a_spread: assert property (p_spread)
		else $error("spread bit or its echo not updated");

	property p_period;
		tick_now |-> (spread_reg ? gap == 4'h7 : gap inside {[4'h6:4'h8]});
	endproperty
	a_period: assert property (p_period)
		else $error("system clock period out of tolerance");

	c_sw_reset: cover property ($fell(sw_active));
	c_normal: cover property (state_reg == ST_NORMAL);
	c_flag_clr: cover property (flag_reg ##1 !flag_reg);
	c_fail: cover property (st_status_reg == `ST_FAIL);

endmodule

// ==== hw/bridge_reset_defines.svh ====
// Constants for the bridge reset and clock control block.
`ifndef BRIDGE_RESET_DEFINES_SVH
`define BRIDGE_RESET_DEFINES_SVH

`define REF_CLK_HZ 40000000
`define POR_DELAY_NS 300000
`define POR_DELAY_CYCLES ((`POR_DELAY_NS) * (`REF_CLK_HZ / 1000000) / 1000)

`define SYS_PERIOD_NOM 4'h8
`define SYS_PERIOD_LOW 4'h7
`define SYS_PERIOD_HIGH 4'h9
`define SW_RESET_TICKS 2'h2

`define CMD_FRAME_CTRL 4'h2
`define CMD_FRAME_CLK 4'h4
`define SW_RESET_MSB 10
`define SW_RESET_LSB 9
`define SW_RESET_CODE 2'h1
`define SELF_TEST_BIT 8
`define SPREAD_BIT 2

`define ANS_FRAME_4 4'h4
`define ANS_FRAME_7B 4'hb
`define ANS_FRAME_7E 4'he
`define ANS_FRAME_8A 4'ha
`define FLAG_BIT 11
`define ST_STATUS_LSB 6

`define RESET_FLAG_INIT 1'b1
`define SPREAD_INIT 1'b0
`define ST_NOT_DONE 3'h0
`define ST_FAIL 3'h4
`define ST_PASS 3'h7

`endif

// ==== hw/bridge_reset_pkg.sv ====
// Types for the bridge reset and clock control block.
package bridge_reset_pkg;

	typedef enum logic [1:0] {
		ST_DISABLED = 2'b00,
		ST_TESTING = 2'b01,
		ST_PASSED = 2'b11,
		ST_NORMAL = 2'b10
	} bridge_state_t;

	typedef logic [3:0] frame_id_t;

endpackage

// ==== tb/host_mcu.sv ====
// Controller and self-test engine model driving the command and answer ports.
`timescale 1ns/1ps
module host_mcu
	import bridge_reset_pkg::*;
(
	input wire logic clk,
	output logic cmd_stb,
	output frame_id_t cmd_frame,
	output logic [15:0] cmd_data,
	output logic ans_stb,
	output frame_id_t ans_frame,
	input wire logic [11:0] ans_data,
	input wire logic st_req,
	output logic st_done,
	output logic st_ok
);
	logic pass_next = 1'b1;
	initial begin
		cmd_stb = 1'b0;
		cmd_frame = 4'h0;
		cmd_data = 16'h0000;
		ans_stb = 1'b0;
		ans_frame = 4'h0;
		st_done = 1'b0;
		st_ok = 1'b0;
	end
	// One frame per strobe; data is scrambled once the strobe drops.
	task automatic cmd(input frame_id_t f, input logic [15:0] v);
		@(negedge clk);
		cmd_stb = 1'b1;
		cmd_frame = f;
		cmd_data = v;
		@(negedge clk);
		cmd_stb = 1'b0;
		cmd_data = ~v;
	endtask
	task automatic ans(input frame_id_t f, output logic [11:0] v);
		@(negedge clk);
		ans_stb = 1'b1;
		ans_frame = f;
		@(negedge clk);
		ans_stb = 1'b0;
		@(negedge clk);
		v = ans_data;
	endtask
	// The result is only valid with the done pulse.
	always @(negedge clk) begin
		if (st_req === 1'b1) begin
			repeat (4) @(negedge clk);
			st_done = 1'b1;
			st_ok = pass_next;
			@(negedge clk);
			st_done = 1'b0;
			st_ok = ~pass_next;
		end
	end
endmodule

// ==== tb/bridge_reset_and_clock_control_tb_top.sv ====
// Testbench for the bridge reset and clock control block.
`timescale 1ns/1ps
module bridge_reset_and_clock_control_tb_top;
	import bridge_reset_pkg::*;
	localparam int PD = 40;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic supply_low = 1'b0;
	logic pwm_in = 1'b0;
	logic cmd_stb, ans_stb, st_done, st_ok, st_req;
	frame_id_t cmd_frame, ans_frame;
	logic [15:0] cmd_data;
	logic [11:0] ans_data, d;
	logic por_n, logic_rst, hiz, tick;
	int err_total = 0;
	int n_tests = 0;
	int n;
	int g;
	int odd;
	frame_id_t rf[6] = '{4'h4, 4'hb, 4'he, 4'he, 4'ha, 4'h1};
	logic [11:0] rx[6] = '{12'h0, 12'h0, 12'h800, 12'h0, 12'h0, 12'h0};
	always #12.5 ref_clk = ~ref_clk;
	bridge_reset_and_clock_control #(.POR_DELAY(PD))
	bridge_reset_and_clock_control_inst (
		.REF_CLK(ref_clk), .RESET(reset), .SUPPLY_LOW(supply_low),
		.PWM_IN(pwm_in), .CMD_STROBE(cmd_stb), .CMD_FRAME(cmd_frame),
		.CMD_DATA(cmd_data), .ANS_STROBE(ans_stb), .ANS_FRAME(ans_frame),
		.ANS_DATA(ans_data), .SELF_TEST_DONE(st_done),
		.SELF_TEST_OK(st_ok), .SELF_TEST_REQUEST(st_req), .POR_N(por_n),
		.LOGIC_RESET(logic_rst), .BRIDGE_HIZ(hiz), .SYS_TICK(tick)
	);
	host_mcu host_mcu_inst (
		.clk(ref_clk), .cmd_stb(cmd_stb), .cmd_frame(cmd_frame),
		.cmd_data(cmd_data), .ans_stb(ans_stb), .ans_frame(ans_frame),
		.ans_data(ans_data), .st_req(st_req), .st_done(st_done),
		.st_ok(st_ok)
	);
	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Counts falling edges until the power-on reset lets go.
	task automatic wait_por;
		n = 0;
		while (por_n !== 1'b1 && n < 200) begin
			n++;
			@(negedge ref_clk);
		end
	endtask
	// Falling edges from the current one to the next system tick.
	task automatic next_tick(output int gap);
		gap = 0;
		do begin
			gap++;
			@(negedge ref_clk);
		end while (tick !== 1'b1 && gap < 20);
	endtask
	task automatic rd(input frame_id_t f, input logic [11:0] exp);
		host_mcu_inst.ans(f, d);
		chk("answer", {4'h0, d}, {4'h0, exp});
	endtask
	initial begin
		repeat (6) @(negedge ref_clk);
		reset = 1'b0;
		chk("por_n", por_n, 0);
		chk("hiz", hiz, 1);
		wait_por();
		chk("por_delay", n <= PD + 1, 1);
		chk("logic_rst", logic_rst, 0);
		for (int i = 0; i < 6; i++) begin
			rd(rf[i], rx[i]);
		end
		host_mcu_inst.cmd(4'h4, 16'h0004);
		rd(4'h4, 12'h004);
		rd(4'hb, 12'h004);
		n = 0;
		while (tick !== 1'b1 && n < 20) begin
			n++;
			@(negedge ref_clk);
		end
		n = 0;
		do begin
			n++;
			@(negedge ref_clk);
		end while (tick !== 1'b1 && n < 20);
		chk("tick_gap", n, 8);
		for (int k = 0; k < 4; k++) begin
			if (k != 1) begin
				host_mcu_inst.cmd(4'h2, {5'h0, 2'(k), 9'h0});
				chk("no_action", logic_rst, 0);
			end
		end
		host_mcu_inst.cmd(4'h2, 16'h0200);
		chk("hiz", hiz, 1);
		n = 0;
		while (logic_rst === 1'b1 && n < 100) begin
			n++;
			chk("por_n", por_n, 1);
			@(negedge ref_clk);
		end
		chk("sw_len", n, 15);
		rd(4'h4, 12'h000);
		rd(4'he, 12'h800);
		next_tick(g);
		n = 0;
		odd = 0;
		repeat (4) begin
			next_tick(g);
			n += g;
			if (g != 8) begin
				odd++;
			end
		end
		chk("spread_sum", n, 32);
		chk("spread_odd", odd, 2);
		pwm_in = ~pwm_in;
		repeat (5) @(negedge ref_clk);
		chk("hiz", hiz, 1);
		host_mcu_inst.pass_next = 1'b0;
		host_mcu_inst.cmd(4'h2, 16'h0100);
		repeat (10) @(negedge ref_clk);
		rd(4'ha, 12'h100);
		host_mcu_inst.pass_next = 1'b1;
		host_mcu_inst.cmd(4'h2, 16'h0100);
		repeat (10) @(negedge ref_clk);
		rd(4'ha, 12'h1c0);
		chk("hiz", hiz, 1);
		pwm_in = ~pwm_in;
		repeat (5) @(negedge ref_clk);
		chk("hiz", hiz, 0);
		supply_low = 1'b1;
		#1;
		chk("por_n", por_n, 0);
		chk("hiz", hiz, 1);
		repeat (3) @(negedge ref_clk);
		supply_low = 1'b0;
		wait_por();
		chk("por_delay", n <= PD + 1, 1);
		rd(4'he, 12'h800);
		rd(4'ha, 12'h000);
		close_out();
	end
	initial begin
		#(25 * 4000);
		err_total++;
		close_out();
	end
endmodule
